// >>> rsm_pkg.sv
// Constants, register map and types for the reference select and input monitor.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
package rsm_pkg;

    // Geometry of the block.
    localparam int NUM_REF  = 4;
    localparam int NUM_PLL  = 2;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int TGT_W    = 17;
    localparam int VCNT_W   = 4;

    // Monitor clock: the PLL0 oscillator divided by eight, stood in for by clk_sys.
    localparam int MON_DIV        = 8;
    localparam int MON_DIV_W      = 3;
    localparam int VALID_EDGES    = 8;
    localparam logic [TGT_W-1:0] TGT_RST = 17'h00100;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PCFG0  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PCFG1  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_EVENT  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_TGT0   = 8'h20;

    // Control register fields.
    localparam int CTRL_BYPASS = 0;
    localparam int CTRL_GAPPED = 1;

    // Per-PLL configuration fields.
    localparam int PC_CHOICE  = 0;  // [1:0]
    localparam int PC_MANREF  = 2;  // [3:2]
    localparam int PC_REVERT  = 4;
    localparam int PC_SWMODE  = 5;
    localparam int PC_SLOPE   = 6;  // [7:6]
    localparam int PC_HSRC    = 8;  // [9:8]
    localparam int PC_PRIO    = 10; // [17:10], two bits per input
    localparam int PC_W       = 18;
    localparam logic [PC_W-1:0] PCFG_RST = 18'h39000;

    // Status register fields.
    localparam int ST_LOS   = 0;
    localparam int ST_SOFT  = 4;
    localparam int ST_STATE = 8;   // two bits per PLL
    localparam int ST_ACT   = 12;  // two bits per PLL
    localparam int ST_HOLD  = 16;
    localparam int EV_W     = 6;   // four LOS changes, two hold entries

    // Reference choice field codes.
    localparam logic [1:0] CHOICE_REG  = 2'h0;
    localparam logic [1:0] CHOICE_PIN  = 2'h1;
    localparam logic [1:0] CHOICE_AUTO = 2'h2;

    // Holdover source codes.
    localparam logic [1:0] HSRC_CENTRE  = 2'h0;
    localparam logic [1:0] HSRC_INSTANT = 2'h1;
    localparam logic [1:0] HSRC_FASTAVG = 2'h2;

    // Status codes of the PLL states.
    localparam logic [1:0] CODE_FREE = 2'h0;
    localparam logic [1:0] CODE_LOCK = 2'h1;
    localparam logic [1:0] CODE_HOLD = 2'h2;

    typedef enum logic [1:0] {ST_FREERUN, ST_LOCKED, ST_HOLDOVER} rsm_state_type;

endpackage

// >>> rsm_ref_select.sv
// Reference selection, PLL state control and loss-of-signal monitor for two PLLs.
// Assumes one 250 MHz clock, a classic Wishbone master, and reference pins that are
// asynchronous to clk_sys and slow enough to be sampled by it.
//
// Behaviour
// - Both PLLs start in free-run after reset.
// - Automatic mode locks once an input is validated.
// - Active fails, none valid: enter holdover promptly.
// - Active fails, another valid: switch hitlessly.
// - Manual uses one input; failure means holdover.
// - Register or pin choice; pins pick inputs.
// - Priorities one to four; pick best valid.
// - Revertive switches to any better valid input.
// - Non-revertive keeps current while it stays valid.
// - Bypass routes input zero and one outward.
// - Monitor counters run at oscillator divided by eight.
// - Counter runs to target; input edge restarts.
// - First expiry: soft alarm, restart, freeze tracking; without gapped mode the PLL switches or enters holdover instead.
// - Second consecutive expiry declares loss of signal.
// - Monitor target is seventeen bits per input.
// - Loss clears after eight edges; errors restart.
// - Loss flags on pins; changes raise interrupt.
// - Gapped mode: holdover only after two periods.
// - Fast average holds latest offset, then slopes.
// - Holdover source: centre, instant or average.
// - Holdover sets hold alarm, pin and interrupt.
// - Per-PLL hitless or slope-limited switching with rate.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module rsm_ref_select
    import rsm_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [ADDR_W-1:0]   wb_adr_i,
    input  wire logic [DATA_W-1:0]   wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    output logic      [DATA_W-1:0]   wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [NUM_REF-1:0]  input_ref,
    input  wire logic [1:0]          pin_reference_select0,
    input  wire logic [1:0]          pin_reference_select1,
    output logic      [NUM_REF-1:0]  los_gpio,
    output logic      [NUM_PLL-1:0]  hold_gpio,
    output logic      [1:0]          pll0_state,
    output logic      [1:0]          pll1_state,
    output logic      [1:0]          pll0_active_ref,
    output logic      [1:0]          pll1_active_ref,
    output logic      [NUM_PLL-1:0]  track_freeze,
    output logic      [NUM_PLL-1:0]  phase_event,
    output logic      [NUM_PLL-1:0]  phase_hitless,
    output logic      [1:0]          pll0_phase_slope_rate,
    output logic      [1:0]          pll1_phase_slope_rate,
    output logic      [1:0]          pll0_holdover_source,
    output logic      [1:0]          pll1_holdover_source,
    output logic      [NUM_PLL-1:0]  hold_latest_offset,
    output logic                     loop_bypass,
    output logic                     out_divider_four,
    output logic                     out_divider_five,
    output logic                     interrupt_out_n
);

    // Picks the valid input with the smallest priority code; bit 2 says one was found.
    function automatic logic [2:0] pick_best(input logic [7:0] prio, input logic [3:0] ok);
        logic [2:0] res;
        res = 3'h0;
        for (int lvl = 3; lvl >= 0; lvl--) begin
            for (int i = 3; i >= 0; i--) begin
                if (ok[i] && prio[2*i +: 2] == 2'(lvl)) begin
                    res = {1'b1, 2'(i)};
                end
            end
        end
        return res;
    endfunction

    function automatic logic [1:0] state_code(input rsm_state_type s);
        logic [1:0] c;
        case (s)
            ST_LOCKED:   c = CODE_LOCK;
            ST_HOLDOVER: c = CODE_HOLD;
            default:     c = CODE_FREE;
        endcase
        return c;
    endfunction

    // Registers written by software.
    logic                 bypass_ff;
    logic                 gapped_ff;
    logic [PC_W-1:0]      pcfg_ff    [NUM_PLL];
    logic [TGT_W-1:0]     tgt_ff     [NUM_REF];
    logic [EV_W-1:0]      event_ff;
    logic [EV_W-1:0]      mask_ff;

    // Synchronisers and monitor state.
    logic [NUM_REF-1:0]   ref_s1_ff, ref_s2_ff, ref_s3_ff, ref_filt_ff;
    logic [3:0]           pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_filt_ff;
    logic [MON_DIV_W-1:0] div_ff;
    logic                 mon_tick_ff;
    logic [TGT_W-1:0]     cnt_ff     [NUM_REF];
    logic [VCNT_W-1:0]    vcnt_ff    [NUM_REF];
    logic [NUM_REF-1:0]   soft_ff, los_ff, los_q_ff;

    // PLL control state.
    rsm_state_type        state_ff     [NUM_PLL];
    rsm_state_type        nxt_state    [NUM_PLL];
    logic [1:0]           act_ff       [NUM_PLL];
    logic [1:0]           nxt_act      [NUM_PLL];
    logic [NUM_PLL-1:0]   nxt_switch;
    logic [NUM_PLL-1:0]   hold_enter;
    logic [NUM_PLL-1:0]   slope_pend_ff;
    logic                 ack_ff;
    logic [DATA_W-1:0]    rdata_ff;

    // Input edges are counted only once the second and third stages agree.
    wire [NUM_REF-1:0] ref_rise   = ref_s2_ff & ref_s3_ff & ~ref_filt_ff;
    wire [NUM_REF-1:0] ref_agree  = ~(ref_s2_ff ^ ref_s3_ff);
    wire [3:0]         pin_agree  = ~(pin_s2_ff ^ pin_s3_ff);
    wire [1:0]         pin_sel [NUM_PLL] = '{pin_filt_ff[1:0], pin_filt_ff[3:2]};

    // An expiry is a monitor tick with no edge where the next count meets the target.
    logic [NUM_REF-1:0] expire;
    always_comb begin
        for (int i = 0; i < NUM_REF; i++) begin
            expire[i] = mon_tick_ff && !ref_rise[i] && ({1'b0, cnt_ff[i]} + 18'h1 >= {1'b0, tgt_ff[i]});
        end
    end

    // Without gapped mode a soft alarm already counts as failure; gapped mode waits for loss.
    wire [NUM_REF-1:0] ref_fail = gapped_ff ? los_ff : (los_ff | soft_ff);

    // Register bus decode.
    wire        wb_req   = wb_cyc_i && wb_stb_i && !ack_ff;
    wire        wb_wr    = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && (wb_sel_i == 4'hf); // Lands with the ack edge.
    wire        hit_ctrl = wb_adr_i == OFF_CTRL;
    wire        hit_pc0  = wb_adr_i == OFF_PCFG0;
    wire        hit_pc1  = wb_adr_i == OFF_PCFG1;
    wire        hit_ev   = wb_adr_i == OFF_EVENT;
    wire        hit_mask = wb_adr_i == OFF_MASK;
    wire        hit_tgt  = wb_adr_i[7:4] == OFF_TGT0[7:4] && wb_adr_i[1:0] == 2'h0;
    wire [1:0]  tgt_idx  = wb_adr_i[3:2];

    // Status word showing the block's own state.
    wire [DATA_W-1:0] status_word = {14'h0, (state_ff[1] == ST_HOLDOVER), (state_ff[0] == ST_HOLDOVER),
                                     act_ff[1], act_ff[0], state_code(state_ff[1]), state_code(state_ff[0]),
                                     soft_ff, los_ff};

    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        case (wb_adr_i)
            OFF_CTRL:   rd_mux = {30'h0, gapped_ff, bypass_ff};
            OFF_PCFG0:  rd_mux = {14'h0, pcfg_ff[0]};
            OFF_PCFG1:  rd_mux = {14'h0, pcfg_ff[1]};
            OFF_STATUS: rd_mux = status_word;
            OFF_EVENT:  rd_mux = {26'h0, event_ff};
            OFF_MASK:   rd_mux = {26'h0, mask_ff};
            default:    rd_mux = hit_tgt ? {15'h0, tgt_ff[tgt_idx]} : 32'h0;
        endcase
    end

    // Single-cycle answer; unmapped addresses are acknowledged and read as zero.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff   <= wb_req;
            rdata_ff <= wb_req ? rd_mux : 32'h0;
        end
    end

    // Software-written configuration. Partial writes are ignored so fields never tear.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bypass_ff  <= 1'b0;
            gapped_ff  <= 1'b0;
            mask_ff    <= 6'h0;
            pcfg_ff[0] <= PCFG_RST;
            pcfg_ff[1] <= PCFG_RST;
            for (int i = 0; i < NUM_REF; i++) begin
                tgt_ff[i] <= TGT_RST;
            end
        end else if (wb_wr) begin
            if (hit_ctrl) begin
                bypass_ff <= wb_dat_i[CTRL_BYPASS];
                gapped_ff <= wb_dat_i[CTRL_GAPPED];
            end
            if (hit_pc0) pcfg_ff[0] <= wb_dat_i[PC_W-1:0];
            if (hit_pc1) pcfg_ff[1] <= wb_dat_i[PC_W-1:0];
            if (hit_mask) mask_ff <= wb_dat_i[EV_W-1:0];
            if (hit_tgt) tgt_ff[tgt_idx] <= wb_dat_i[TGT_W-1:0];
        end
    end

    // Event flags: hardware set wins over a write-one-to-clear in the same cycle.
    wire [EV_W-1:0] ev_set = {hold_enter, los_ff ^ los_q_ff};
    wire [EV_W-1:0] ev_clr = (wb_wr && hit_ev) ? wb_dat_i[EV_W-1:0] : 6'h0;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            event_ff <= 6'h0;
            los_q_ff <= 4'h0;
        end else begin
            event_ff <= (event_ff & ~ev_clr) | ev_set;
            los_q_ff <= los_ff;
        end
    end

    // Three-stage synchronisers for reference and select pins.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_s1_ff   <= 4'h0;
            ref_s2_ff   <= 4'h0;
            ref_s3_ff   <= 4'h0;
            ref_filt_ff <= 4'h0;
            pin_s1_ff   <= 4'h0;
            pin_s2_ff   <= 4'h0;
            pin_s3_ff   <= 4'h0;
            pin_filt_ff <= 4'h0;
        end else begin
            ref_s1_ff   <= input_ref;
            ref_s2_ff   <= ref_s1_ff;
            ref_s3_ff   <= ref_s2_ff;
            ref_filt_ff <= (ref_filt_ff & ~ref_agree) | (ref_s2_ff & ref_agree);
            pin_s1_ff   <= {pin_reference_select1, pin_reference_select0};
            pin_s2_ff   <= pin_s1_ff;
            pin_s3_ff   <= pin_s2_ff;
            pin_filt_ff <= (pin_filt_ff & ~pin_agree) | (pin_s2_ff & pin_agree);
        end
    end

    // Monitor tick divider; the cnt_ff counters only advance on this enable.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_ff      <= 3'h0;
            mon_tick_ff <= 1'b0;
        end else begin
            div_ff      <= div_ff + 3'h1;
            mon_tick_ff <= (div_ff == 3'(MON_DIV - 1));
        end
    end

    // One independent monitor per input, shared by both PLLs.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_ff <= 4'h0;
            los_ff  <= 4'h0;
            for (int i = 0; i < NUM_REF; i++) begin
                cnt_ff[i]  <= 17'h0;
                vcnt_ff[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < NUM_REF; i++) begin
                if (ref_rise[i]) begin
                    cnt_ff[i]  <= 17'h0;
                    soft_ff[i] <= 1'b0;
                    if (los_ff[i] && vcnt_ff[i] == 4'(VALID_EDGES - 1)) begin
                        los_ff[i]  <= 1'b0;
                        vcnt_ff[i] <= 4'h0;
                    end else if (los_ff[i]) begin
                        vcnt_ff[i] <= vcnt_ff[i] + 4'h1;
                    end
                end else if (expire[i]) begin
                    cnt_ff[i]  <= 17'h0;
                    soft_ff[i] <= 1'b1;
                    if (soft_ff[i] || los_ff[i]) begin
                        los_ff[i]  <= 1'b1;
                        vcnt_ff[i] <= 4'h0;
                    end
                end else if (mon_tick_ff) begin
                    cnt_ff[i] <= cnt_ff[i] + 17'h1;
                end
            end
        end
    end

    // Next state and active input of each PLL.
    always_comb begin
        for (int p = 0; p < NUM_PLL; p++) begin
            logic [1:0] choice;
            logic [1:0] sel;
            logic [7:0] prio;
            logic [2:0] best;
            choice        = pcfg_ff[p][PC_CHOICE +: 2];
            prio          = pcfg_ff[p][PC_PRIO +: 8];
            sel           = (choice == CHOICE_PIN) ? pin_sel[p] : pcfg_ff[p][PC_MANREF +: 2];
            best          = pick_best(prio, ~ref_fail);
            nxt_state[p]  = state_ff[p];
            nxt_act[p]    = act_ff[p];
            nxt_switch[p] = 1'b0;
            case (state_ff[p])
                ST_FREERUN, ST_HOLDOVER: begin
                    if (choice == CHOICE_AUTO) begin
                        if (best[2]) begin
                            nxt_state[p] = ST_LOCKED;
                            nxt_act[p]   = best[1:0];
                        end
                    end else if (!ref_fail[sel]) begin
                        nxt_state[p] = ST_LOCKED;
                        nxt_act[p]   = sel;
                    end
                end
                ST_LOCKED: begin
                    if (choice == CHOICE_AUTO) begin
                        if (ref_fail[act_ff[p]]) begin
                            if (best[2]) begin
                                nxt_act[p]    = best[1:0];
                                nxt_switch[p] = 1'b1;
                            end else begin
                                nxt_state[p] = ST_HOLDOVER;
                            end
                        end else if (pcfg_ff[p][PC_REVERT] && best[2] &&
                                     prio[2*best[1:0] +: 2] < prio[2*act_ff[p] +: 2]) begin
                            nxt_act[p]    = best[1:0];
                            nxt_switch[p] = 1'b1;
                        end
                    end else if (ref_fail[sel]) begin
                        nxt_state[p] = ST_HOLDOVER;
                        nxt_act[p]   = sel;
                    end else if (sel != act_ff[p]) begin
                        nxt_act[p]    = sel;
                        nxt_switch[p] = 1'b1;
                    end
                end
                default: nxt_state[p] = ST_FREERUN;
            endcase
            hold_enter[p] = (nxt_state[p] == ST_HOLDOVER) && (state_ff[p] != ST_HOLDOVER);
        end
    end

    // PLL state registers and the outputs that follow them.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < NUM_PLL; p++) begin
                state_ff[p] <= ST_FREERUN;
                act_ff[p]   <= 2'h0;
            end
            track_freeze       <= 2'h0;
            phase_event        <= 2'h0;
            phase_hitless      <= 2'h0;
            hold_latest_offset <= 2'h0;
            slope_pend_ff      <= 2'h0;
            hold_gpio          <= 2'h0;
        end else begin
            for (int p = 0; p < NUM_PLL; p++) begin
                state_ff[p]        <= nxt_state[p];
                act_ff[p]          <= nxt_act[p];
                hold_gpio[p]       <= nxt_state[p] == ST_HOLDOVER;
                track_freeze[p]    <= nxt_state[p] == ST_LOCKED && soft_ff[nxt_act[p]];
                phase_event[p]     <= nxt_switch[p] || (nxt_state[p] != state_ff[p]);
                if (nxt_switch[p] || nxt_state[p] != state_ff[p]) begin
                    phase_hitless[p] <= pcfg_ff[p][PC_SWMODE];
                end
                // Fast average first holds the latest offset until the next monitor tick, then slopes.
                if (hold_enter[p] && pcfg_ff[p][PC_HSRC +: 2] == HSRC_FASTAVG) begin
                    hold_latest_offset[p] <= 1'b1;
                    slope_pend_ff[p]      <= 1'b1;
                end else if (nxt_state[p] != ST_HOLDOVER || (slope_pend_ff[p] && mon_tick_ff)) begin
                    hold_latest_offset[p] <= 1'b0;
                    slope_pend_ff[p]      <= 1'b0;
                end
            end
        end
    end

    // Flopped pin outputs, codes and bypass routing.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            los_gpio              <= 4'h0;
            pll0_state            <= CODE_FREE;
            pll1_state            <= CODE_FREE;
            pll0_active_ref       <= 2'h0;
            pll1_active_ref       <= 2'h0;
            pll0_phase_slope_rate <= 2'h0;
            pll1_phase_slope_rate <= 2'h0;
            pll0_holdover_source  <= HSRC_CENTRE;
            pll1_holdover_source  <= HSRC_CENTRE;
            loop_bypass           <= 1'b0;
            out_divider_four      <= 1'b0;
            out_divider_five      <= 1'b0;
            interrupt_out_n       <= 1'b1;
        end else begin
            los_gpio              <= los_ff;
            pll0_state            <= state_code(nxt_state[0]);
            pll1_state            <= state_code(nxt_state[1]);
            pll0_active_ref       <= nxt_act[0];
            pll1_active_ref       <= nxt_act[1];
            pll0_phase_slope_rate <= pcfg_ff[0][PC_SLOPE +: 2];
            pll1_phase_slope_rate <= pcfg_ff[1][PC_SLOPE +: 2];
            pll0_holdover_source  <= pcfg_ff[0][PC_HSRC +: 2];
            pll1_holdover_source  <= pcfg_ff[1][PC_HSRC +: 2];
            loop_bypass           <= bypass_ff;
            out_divider_four      <= bypass_ff & ref_filt_ff[0];
            out_divider_five      <= bypass_ff & ref_filt_ff[1];
            interrupt_out_n       <= ~|(event_ff & mask_ff);
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

endmodule // rsm_ref_select

// >>> rsm_ref_src.sv
// Model of the four reference clock sources beside the selection block.
// Assumes clk_sys from the bench; a running source toggles every HALF cycles.
`timescale 1ns/1ps
module rsm_ref_src #(
    parameter int HALF = 8
) (
    input  wire logic       clk_sys,
    input  wire logic [3:0] run,
    output logic      [3:0] input_ref
);
    int cnt = 0;

    // A stopped source freezes at its level, as a dead oscillator would.
    always @(posedge clk_sys) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) input_ref <= input_ref ^ run;
    end

    initial input_ref = 4'h0;
endmodule // rsm_ref_src

// >>> rsm_ref_select_assertions.sv
// Concurrent checks on the ports of the reference selection block.
// Assumes one clk_sys domain with an asynchronous active-low reset.
`timescale 1ns/1ps
module rsm_ref_select_assertions
    import rsm_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [1:0] hold_gpio,
    input wire logic [1:0] pll0_state,
    input wire logic [1:0] pll0_active_ref,
    input wire logic [1:0] phase_event,
    input wire logic [1:0] track_freeze,
    input wire logic [1:0] hold_latest_offset,
    input wire logic [1:0] pll0_holdover_source,
    input wire logic       loop_bypass,
    input wire logic       out_divider_four
);
    wire locked0 = (pll0_state == CODE_LOCK);

    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // A taken request gets exactly one ack pulse, one cycle later.
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    bus_answer_a: assert property (req_taken |=> ack_once)
        else $error("request not answered by one ack pulse");
    bus_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");

    // Every move of PLL0 is announced by a single-cycle phase event.
    sequence event_pulse;
        phase_event[0] ##1 !phase_event[0];
    endsequence
    state_event_a: assert property ($changed(pll0_state) |-> event_pulse)
        else $error("state change without phase event");
    switch_event_a: assert property ($changed(pll0_active_ref) && $stable(locked0) && locked0 |-> event_pulse)
        else $error("reference switch without phase event");

    hold_pin_a: assert property (hold_gpio[0] == (pll0_state == CODE_HOLD))
        else $error("hold pin and state disagree");
    bypass_gate_a: assert property (!loop_bypass && !$past(loop_bypass) |-> !out_divider_four)
        else $error("bypass output active without bypass");
    freeze_lock_a: assert property (track_freeze[0] |-> locked0)
        else $error("tracking frozen outside lock");
    offset_source_a: assert property ($rose(hold_latest_offset[0]) |-> pll0_holdover_source == HSRC_FASTAVG)
        else $error("latest offset held outside fast average");
endmodule // rsm_ref_select_assertions

// >>> rsm_ref_select_tb.sv
// Self-checking bench for the reference selection block.
// Assumes the source model and the checker are compiled before this file.
`timescale 1ns/1ps
module rsm_ref_select_tb
    import rsm_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
    logic [3:0]  run = 4'hf, input_ref, los_gpio;
    logic [1:0]  sel0 = 2'h0, sel1 = 2'h0, hold_gpio, phase_event, track_freeze, hold_latest_offset;
    logic [1:0]  pll0_state, pll1_state, pll0_active_ref, pll1_active_ref, pll0_holdover_source, exp_ref;
    logic        loop_bypass, out_divider_four, interrupt_out_n;
    logic [15:0] lfsr = 16'habe5;
    int          n_tests = 0, n_mismatch = 0, cyc = 0;

    rsm_ref_src rsm_ref_src_inst (.clk_sys, .run, .input_ref);
    rsm_ref_select rsm_ref_select_inst (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i(4'hf), .wb_dat_o, .wb_ack_o, .input_ref, .pin_reference_select0(sel0),
        .pin_reference_select1(sel1), .los_gpio, .hold_gpio, .pll0_state, .pll1_state, .pll0_active_ref,
        .pll1_active_ref, .track_freeze, .phase_event, .phase_hitless(), .pll0_phase_slope_rate(),
        .pll1_phase_slope_rate(), .pll0_holdover_source, .pll1_holdover_source(), .hold_latest_offset,
        .loop_bypass, .out_divider_four, .out_divider_five(), .interrupt_out_n);

    // The clock toggles every half period of 2 ns.
    always #2 clk_sys = ~clk_sys;

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Configuration word with default priorities, hitless switching and fast-average holdover.
    function automatic logic [31:0] cfg(input logic [1:0] ch, input logic [1:0] man, input logic rev);
        return {14'h0, PCFG_RST[17:10], HSRC_FASTAVG, 2'h0, 1'b1, rev, man, ch};
    endfunction

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cuts a hang short; the whole sequence needs well under 2000 cycles.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    // Main sequence: sources run at 16 cycles a period, targets of 4 ticks.
    initial begin
        wait_cyc(20);
        rst_n <= 1'b1;
        wait_cyc(1);
        chk(pll0_state, CODE_FREE);
        chk(pll1_state, CODE_FREE);
        rd_chk(OFF_PCFG0, PCFG_RST);
        rd_chk(OFF_TGT0, TGT_RST);
        rd_chk(8'h40, 32'h0);
        bus(1'b1, OFF_TGT0 + 8'h0c, 32'hffffffff);
        rd_chk(OFF_TGT0 + 8'h0c, 32'h1ffff);
        for (int i = 0; i < 4; i++) bus(1'b1, OFF_TGT0 + 8'(4 * i), 32'h4);
        bus(1'b1, OFF_MASK, 32'h20);
        bus(1'b1, OFF_PCFG0, cfg(CHOICE_AUTO, 2'h0, 1'b1));
        bus(1'b1, OFF_PCFG1, cfg(CHOICE_AUTO, 2'h0, 1'b0));
        wait_cyc(100);
        chk(pll0_state, CODE_LOCK);
        chk(pll0_active_ref, 2'h0);
        bus(1'b1, OFF_CTRL, 32'h2);
        run <= 4'he;
        wait_cyc(42);
        chk(track_freeze, 2'h3);
        wait_cyc(108);
        chk(los_gpio, 4'h1);
        chk(pll0_active_ref, 2'h1);
        run <= 4'hf;
        wait_cyc(300);
        chk(los_gpio, 4'h0);
        chk(pll0_active_ref, 2'h0);
        chk(pll1_active_ref, 2'h1);
        bus(1'b1, OFF_PCFG1, cfg(CHOICE_PIN, 2'h0, 1'b0));
        lfsr = lfsr_next(lfsr);
        for (int i = 0; i < 4; i++) begin
            exp_ref = 2'(i) ^ lfsr[1:0];
            sel1 <= exp_ref;
            sel0 <= lfsr[3:2];
            wait_cyc(20);
            chk(pll1_active_ref, exp_ref);
        end
        bus(1'b1, OFF_PCFG1, cfg(CHOICE_REG, 2'h2, 1'b0));
        wait_cyc(20);
        chk(pll1_active_ref, 2'h2);
        run <= 4'hb;
        wait_cyc(150);
        chk(pll1_state, CODE_HOLD);
        chk(pll1_active_ref, 2'h2);
        chk(hold_gpio, 2'h2);
        chk(interrupt_out_n, 1'b0);
        rd_chk(OFF_EVENT, 32'h25);
        bus(1'b1, OFF_EVENT, 32'h3f);
        rd_chk(OFF_EVENT, 32'h0);
        chk(interrupt_out_n, 1'b1);
        run <= 4'h0;
        wait_cyc(150);
        chk(pll0_state, CODE_HOLD);
        chk(hold_gpio, 2'h3);
        run <= 4'hf;
        bus(1'b1, OFF_CTRL, 32'h1); // Sources here run far below the bypass limit.
        wait_cyc(2);
        chk(loop_bypass, 1'b1);
        report_and_stop;
    end
endmodule // rsm_ref_select_tb

bind rsm_ref_select rsm_ref_select_assertions rsm_ref_select_assertions_inst (.clk_sys, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .hold_gpio, .pll0_state, .pll0_active_ref, .phase_event, .track_freeze,
    .hold_latest_offset, .pll0_holdover_source, .loop_bypass, .out_divider_four);
